// File: hpp_pkg.sv
// shared constants and types for the 8-bit parallel host port
package hpp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned HOST_CLK_MAX_MHZ = 66;
  localparam int unsigned REF_CLK_MHZ = 50;
  localparam logic [2:0] STYLE_CODE_SEP = 3'h0;
  localparam logic [2:0] STYLE_CODE_RWS = 3'h1;
  localparam logic [2:0] STYLE_CODE_BURST = 3'h2;
  localparam logic [3:0] WAIT_CYCLES = 4'h2;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] IRQ_TRIGGER_ADDR = 8'hFF;
  localparam logic [7:0] IRQ_CLEAR_ADDR = 8'hFE;
  localparam logic [1:0] HOST_STROBE_HOLD = 2'h2;
  typedef enum logic [1:0] {HPP_STYLE_SEP, HPP_STYLE_RWS, HPP_STYLE_BURST, HPP_STYLE_BAD} hpp_style_e;
endpackage

// File: hpp_if.sv
// pin-level carrier between host and device ends
`timescale 1ns/1ns
interface hpp_if;
  logic [2:0] bus_style_select;
  logic [7:0] addr;
  logic [7:0] host_data_out;
  logic host_data_oe;
  logic [7:0] dev_data_out;
  logic dev_data_oe;
  logic [7:0] host_data_io;
  logic write_strobe_or_dir_n;
  logic read_or_data_strobe_n;
  logic addr_latch_strobe;
  logic port_select_n;
  logic ready_or_ack_n;
  logic data_drive_enable_n;
  logic burst_last_n;
  logic irq_out;
  logic irq_oe;
  logic irq_request_n;
  assign host_data_io = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 8'hFF);
  assign irq_request_n = irq_oe ? irq_out : 1'b1;
  modport device (
    input bus_style_select, addr, host_data_io, write_strobe_or_dir_n,
    input read_or_data_strobe_n, addr_latch_strobe, port_select_n,
    input data_drive_enable_n, burst_last_n,
    output dev_data_out, dev_data_oe, ready_or_ack_n, irq_out, irq_oe
  );
  modport host (
    output bus_style_select, addr, host_data_out, host_data_oe, write_strobe_or_dir_n,
    output read_or_data_strobe_n, addr_latch_strobe, port_select_n,
    output data_drive_enable_n, burst_last_n,
    input host_data_io, ready_or_ack_n, irq_request_n
  );
endinterface

// File: hpp_device.sv
// device end: register/ram space behind the parallel host port
`timescale 1ns/1ns
// Functional notes
// - one synchronous clock serves all transfer styles
// - style inputs choose strobe and handshake behaviour
// - address selects register or ram location
// - separate strobe mode: write strobe captures data
// - select mode: write pin high reads, low writes
// - separate strobe mode: read strobe drives data
// - data bus released when read strobe ends
// - select mode: read pin is data strobe
// - address strobe latches address, polarity per style
// - strobes ignored without chip select
// - ready low stretches separate strobe cycles
// - select mode ack delayed until nearly done
// - burst mode: drive enable gates data drivers
// - host marks burst end with last low
// - open drain interrupt low while service needed
// - reset clears port state but not the register/ram space, releases all outputs
module hpp_device #(
  parameter logic [2:0] CODE_SEP = hpp_pkg::STYLE_CODE_SEP,
  parameter logic [2:0] CODE_RWS = hpp_pkg::STYLE_CODE_RWS,
  parameter logic [2:0] CODE_BURST = hpp_pkg::STYLE_CODE_BURST,
  parameter int unsigned DEPTH = 256
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  hpp_if.device bus,
  input wire logic service_req,
  output logic [7:0] last_write_addr,
  output logic write_seen
);
  // the decode below serves a full byte address space only
  if (DEPTH != 256) begin : g_bad_depth
    $error("hpp_device: DEPTH must be 256");
  end
  // two styles on one code would make the decode ambiguous
  if (CODE_SEP == CODE_RWS) begin : g_bad_code_a
    $error("hpp_device: style codes must differ");
  end
  if (CODE_SEP == CODE_BURST) begin : g_bad_code_b
    $error("hpp_device: style codes must differ");
  end
  if (CODE_RWS == CODE_BURST) begin : g_bad_code_c
    $error("hpp_device: style codes must differ");
  end
  if (hpp_pkg::REF_CLK_MHZ > hpp_pkg::HOST_CLK_MAX_MHZ) begin : g_bad_clock
    $error("hpp_device: clock above supported rate");
  end
  typedef enum logic [1:0] {HPP_IDLE, HPP_WAIT, HPP_DONE} hpp_phase_e;
  typedef struct packed {
    hpp_phase_e phase;
    logic [7:0] addr;
    logic rd;
    logic [3:0] wait_cnt;
    logic [7:0] dout;
    logic doe;
    logic rdy_n;
    logic irq_flag;
    logic irq_oe;
    logic [7:0] wr_addr;
    logic wr_seen;
    logic we;
    logic [7:0] wdata;
  } hpp_state_s;
  hpp_state_s st_reg;
  hpp_state_s st_next;
  logic [7:0] mem [0:255];
  hpp_pkg::hpp_style_e style;
  logic strobe;
  logic as_on;
  logic rd_req;
  logic wr_req;
  logic drv_ok;
  always_comb begin
    // style pins are static, so they are read without a synchroniser
    if (bus.bus_style_select == CODE_SEP) begin
      style = hpp_pkg::HPP_STYLE_SEP;
    end else if (bus.bus_style_select == CODE_RWS) begin
      style = hpp_pkg::HPP_STYLE_RWS;
    end else if (bus.bus_style_select == CODE_BURST) begin
      style = hpp_pkg::HPP_STYLE_BURST;
    end else begin
      style = hpp_pkg::HPP_STYLE_BAD;
    end
  end
  always_comb begin
    rd_req = 1'b0;
    wr_req = 1'b0;
    as_on = 1'b0;
    drv_ok = 1'b1;
    unique case (style)
      hpp_pkg::HPP_STYLE_SEP, hpp_pkg::HPP_STYLE_BURST: begin
        as_on = bus.addr_latch_strobe;
        rd_req = !bus.read_or_data_strobe_n;
        wr_req = !bus.write_strobe_or_dir_n;
        if (style == hpp_pkg::HPP_STYLE_BURST) begin
          drv_ok = !bus.data_drive_enable_n;
        end
      end
      hpp_pkg::HPP_STYLE_RWS: begin
        as_on = !bus.addr_latch_strobe;
        rd_req = !bus.read_or_data_strobe_n && bus.write_strobe_or_dir_n;
        wr_req = !bus.read_or_data_strobe_n && !bus.write_strobe_or_dir_n;
      end
      default: begin
        as_on = 1'b0;
      end
    endcase
    if (bus.port_select_n) begin
      rd_req = 1'b0;
      wr_req = 1'b0;
      as_on = 1'b0;
    end
    strobe = rd_req || wr_req;
  end
  always_comb begin
    st_next = st_reg;
    st_next.we = 1'b0;
    if (as_on) begin
      st_next.addr = bus.addr;
    end
    unique case (st_reg.phase)
      HPP_IDLE: begin
        st_next.rdy_n = 1'b1;
        if (strobe) begin
          st_next.phase = HPP_WAIT;
          st_next.rd = rd_req;
          st_next.wait_cnt = hpp_pkg::WAIT_CYCLES;
          // separate strobe styles drop ready to stretch the cycle
          if (style != hpp_pkg::HPP_STYLE_RWS) begin
            st_next.rdy_n = 1'b0;
          end
        end
      end
      HPP_WAIT: begin
        if (!strobe) begin
          st_next.phase = HPP_IDLE;
          st_next.rdy_n = 1'b1;
        end else if (st_reg.wait_cnt == 4'h0) begin
          st_next.phase = HPP_DONE;
          if (st_reg.rd) begin
            st_next.dout = mem[st_reg.addr];
          end else begin
            st_next.we = 1'b1;
            st_next.wdata = bus.host_data_io;
            st_next.wr_addr = st_reg.addr;
            st_next.wr_seen = 1'b1;
          end
          // high in separate styles releases the stretch, low in select style acks
          st_next.rdy_n = (style == hpp_pkg::HPP_STYLE_RWS) ? 1'b0 : 1'b1;
        end else begin
          st_next.wait_cnt = st_reg.wait_cnt - 4'h1;
        end
      end
      HPP_DONE: begin
        st_next.wr_seen = 1'b0;
        // burst keeps going when the address strobe repeats during the strobe, unless last was marked
        if (!strobe) begin
          st_next.phase = HPP_IDLE;
          st_next.rdy_n = 1'b1;
        end else if (style == hpp_pkg::HPP_STYLE_BURST && bus.burst_last_n && as_on) begin
          st_next.phase = HPP_WAIT;
          st_next.wait_cnt = hpp_pkg::WAIT_CYCLES;
        end
      end
      default: st_next.phase = HPP_IDLE;
    endcase
    st_next.doe = (st_next.phase == HPP_DONE) && st_next.rd && rd_req && drv_ok;
    // set wins over clear
    if (service_req) begin
      st_next.irq_flag = 1'b1;
    end else if (st_reg.we && st_reg.wr_addr == hpp_pkg::IRQ_CLEAR_ADDR) begin
      st_next.irq_flag = 1'b0;
    end
    if (st_reg.we && st_reg.wr_addr == hpp_pkg::IRQ_TRIGGER_ADDR) begin
      st_next.irq_flag = 1'b1;
    end
    st_next.irq_oe = st_next.irq_flag;
  end
  // one clock times every style, burst included
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.phase <= HPP_IDLE;
      st_reg.rdy_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  // ram has no reset; each location is defined only after its first write
  always_ff @(posedge ref_clk) begin
    if (st_reg.we) mem[st_reg.wr_addr] <= st_reg.wdata;
  end
  assign bus.dev_data_out = st_reg.dout;
  assign bus.dev_data_oe = st_reg.doe;
  assign bus.ready_or_ack_n = st_reg.rdy_n;
  assign bus.irq_out = 1'b0;
  assign bus.irq_oe = st_reg.irq_oe;
  assign last_write_addr = st_reg.wr_addr;
  assign write_seen = st_reg.wr_seen;
endmodule

// File: hpp_host.sv
// host end: runs single read or write cycles on the parallel port
`timescale 1ns/1ns
module hpp_host #(
  parameter logic [2:0] STYLE_CODE = hpp_pkg::STYLE_CODE_SEP,
  parameter logic rws_style = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  hpp_if.host bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_last,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_busy,
  output logic resp_valid,
  output logic [7:0] resp_rdata,
  output logic irq_seen
);
  typedef enum logic [1:0] {HPH_IDLE, HPH_ADDR, HPH_STROBE, HPH_END} hph_phase_e;
  typedef struct packed {
    hph_phase_e phase;
    logic wr;
    logic last;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic cs_n;
    logic as;
    logic strobe;
    logic [1:0] hold;
    logic busy;
    logic rv;
    logic irq;
  } hph_state_s;
  hph_state_s st_reg;
  hph_state_s st_next;
  logic done;
  always_comb begin
    // ready high ends a separate strobe cycle, ack low ends a select cycle
    done = rws_style ? !bus.ready_or_ack_n : bus.ready_or_ack_n;
    st_next = st_reg;
    st_next.rv = 1'b0;
    st_next.irq = !bus.irq_request_n;
    unique case (st_reg.phase)
      HPH_IDLE: begin
        if (req_valid) begin
          st_next.phase = HPH_ADDR;
          st_next.wr = req_write;
          st_next.last = req_last;
          st_next.addr = req_addr;
          st_next.wdata = req_wdata;
          st_next.cs_n = 1'b0;
          st_next.as = 1'b1;
          st_next.busy = 1'b1;
        end
      end
      HPH_ADDR: begin
        st_next.as = 1'b0;
        st_next.strobe = 1'b1;
        st_next.hold = hpp_pkg::HOST_STROBE_HOLD;
        st_next.phase = HPH_STROBE;
      end
      HPH_STROBE: begin
        // device needs a few cycles before its ready reflects the cycle
        if (st_reg.hold != 2'h0) st_next.hold = st_reg.hold - 2'h1;
        else if (done) begin
          st_next.rdata = bus.host_data_io;
          st_next.strobe = 1'b0;
          st_next.phase = HPH_END;
        end
      end
      HPH_END: begin
        st_next.cs_n = 1'b1;
        st_next.busy = 1'b0;
        st_next.rv = !st_reg.wr;
        st_next.phase = HPH_IDLE;
      end
      default: st_next.phase = HPH_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.phase <= HPH_IDLE;
      st_reg.cs_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  assign bus.bus_style_select = STYLE_CODE;
  assign bus.addr = st_reg.addr;
  assign bus.host_data_out = st_reg.wdata;
  assign bus.host_data_oe = st_reg.wr && st_reg.strobe;
  assign bus.port_select_n = st_reg.cs_n;
  assign bus.addr_latch_strobe = rws_style ? !st_reg.as : st_reg.as;
  assign bus.write_strobe_or_dir_n = rws_style ? !st_reg.wr : !(st_reg.strobe && st_reg.wr);
  assign bus.read_or_data_strobe_n = rws_style ? !st_reg.strobe : !(st_reg.strobe && !st_reg.wr);
  assign bus.data_drive_enable_n = !(st_reg.strobe && !st_reg.wr);
  assign bus.burst_last_n = !st_reg.last;
  assign req_busy = st_reg.busy;
  assign resp_valid = st_reg.rv;
  assign resp_rdata = st_reg.rdata;
  assign irq_seen = st_reg.irq;
endmodule

// File: hpp_properties.sv
// concurrent checks on the host port wires
`timescale 1ns/1ns
module hpp_properties (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic port_select_n,
  input wire logic read_or_data_strobe_n,
  input wire logic write_strobe_or_dir_n,
  input wire logic ready_or_ack_n,
  input wire logic dev_data_oe,
  input wire logic irq_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence port_idle;
    port_select_n [*3];
  endsequence
  sequence wait_stretch;
    !ready_or_ack_n ##[1:6] ready_or_ack_n;
  endsequence
  a_strobe_after_select: assert property ($fell(read_or_data_strobe_n && write_strobe_or_dir_n)
    |-> !port_select_n && $past(!port_select_n)) else $error("strobe without select");
  a_ready_stretch_bound: assert property ($fell(read_or_data_strobe_n && write_strobe_or_dir_n)
    |-> ##[1:3] wait_stretch) else $error("ready stretch missing or too long");
  a_hold_in_wait: assert property (!ready_or_ack_n
    |-> !port_select_n && !(read_or_data_strobe_n && write_strobe_or_dir_n))
    else $error("cycle dropped while stretched");
  a_one_strobe_only: assert property (read_or_data_strobe_n || write_strobe_or_dir_n)
    else $error("both strobes active");
  a_drive_on_read: assert property ($rose(dev_data_oe)
    |-> !read_or_data_strobe_n && !port_select_n) else $error("drive without read");
  a_release_read: assert property (dev_data_oe && read_or_data_strobe_n |=> !dev_data_oe)
    else $error("data bus not released");
  a_idle_quiet: assert property (port_idle |-> !dev_data_oe && ready_or_ack_n)
    else $error("device active while deselected");
  a_reset_quiet: assert property ($rose(rst_b) |-> !dev_data_oe && !irq_oe && ready_or_ack_n)
    else $error("outputs active out of reset");
endmodule

// File: tb_top.sv
// self-checking bench: host and device ends joined over the port
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic service_req = 1'b0;
  logic req_busy, resp_valid, irq_seen, write_seen;
  logic [7:0] resp_rdata, last_write_addr;
  int miscompares = 0;
  int check_count = 0;
  logic [7:0] addr_tab [4] = '{8'h00, 8'h7F, 8'h80, 8'hFD};
  hpp_if bus_if ();
  hpp_host hpp_host_inst (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus_if.host),
    .req_valid(req_valid), .req_write(req_write), .req_last(1'b0), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_busy(req_busy), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .irq_seen(irq_seen));
  hpp_device hpp_device_inst (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus_if.device),
    .service_req(service_req), .last_write_addr(last_write_addr), .write_seen(write_seen));
  hpp_properties hpp_properties_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .port_select_n(bus_if.port_select_n), .read_or_data_strobe_n(bus_if.read_or_data_strobe_n),
    .write_strobe_or_dir_n(bus_if.write_strobe_or_dir_n),
    .ready_or_ack_n(bus_if.ready_or_ack_n), .dev_data_oe(bus_if.dev_data_oe),
    .irq_oe(bus_if.irq_oe));
  always #10 ref_clk = ~ref_clk;
  task automatic end_sim();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one whole cycle; write checks the captured address, read the returned byte
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge ref_clk);
    req_valid = 1'b0;
    n = 0;
    while (n < 40 && (wr ? write_seen : resp_valid) !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK("done", 1'b1, n < 40)
    if (wr) `CHK("waddr", a, last_write_addr)
    else `CHK("rdata", d, resp_rdata)
    n = 0;
    while (n < 40 && req_busy !== 1'b0) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    repeat (2) @(negedge ref_clk);
    `CHK("bus_free", 8'hFF, bus_if.host_data_io)
  endtask
  initial begin
    #50000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    `CHK("irq_rst", 1'b0, irq_seen)
    `CHK("oe_rst", 1'b0, bus_if.dev_data_oe)
    foreach (addr_tab[i]) xfer(1'b1, addr_tab[i], addr_tab[i] ^ 8'hA5);
    foreach (addr_tab[i]) xfer(1'b0, addr_tab[i], addr_tab[i] ^ 8'hA5);
    xfer(1'b1, 8'hFF, 8'h01);
    `CHK("irq_set", 1'b1, irq_seen)
    xfer(1'b1, 8'hFE, 8'h01);
    `CHK("irq_clr", 1'b0, irq_seen)
    service_req = 1'b1;
    repeat (8) @(negedge ref_clk);
    `CHK("irq_svc", 1'b1, irq_seen)
    `CHK("irq_pin", 1'b0, bus_if.irq_request_n)
    service_req = 1'b0;
    xfer(1'b1, 8'hFE, 8'h00);
    `CHK("irq_off", 1'b1, bus_if.irq_request_n)
    xfer(1'b1, 8'hFF, 8'h00);
    // mid-run reset must drop a pending request even though nothing cleared it
    rst_b = 1'b0;
    @(negedge ref_clk);
    `CHK("irq_mid", 1'b1, bus_if.irq_request_n)
    `CHK("seen_mid", 1'b0, irq_seen)
    rst_b = 1'b1;
    xfer(1'b0, 8'h7F, 8'h7F ^ 8'hA5);
    end_sim();
  end
endmodule
